//--- hdl/conv_ctrl.v
// Contract
// - enable bit 0 holds converter in shutdown; 1 makes it ready.
// - track mode 0 and enabled: track always except during conversion.
// - track mode 1, source 00: busy write starts three sar clocks tracking.
// - track mode 1: sources 01/11 start tracking on timer 3/2 overflow.
// - track mode 1, source 10: track only while start pin low.
// - completion sets done flag; only software clears it.
// - busy reads 1 during conversion, 0 otherwise and after reset; the code also reads 1 during the three sar clocks of tracking in track mode 1.
// - interrupt request on falling busy edge when enabled.
// - busy write of 1 starts conversion only in source 00.
// - start source field picks busy write, timer 3, pin edge, timer 2.
// - window hit sets window flag; software clears it.
// - right justify: sign copies in differential, else high nibble zero.
// - left justify: upper eight in high byte, low nibble zero.
// - single ended results are unsigned binary.
// - differential results are two's complement.
// - every result compared against limits; flag pollable or interrupting.
// - lower limit from greater-than bytes, upper from less-than bytes.
// - upper above lower flags results strictly between limits.
// - otherwise flags results below upper or above lower limit.
// - differential mode compares limits and result as signed.
`include "conv_ctrl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl
#(
    parameter SAR_DIV = 4
)
(
    input  wire        i_mclk,
    input  wire        i_resetn,
    input  wire [7:0]  i_addr,
    input  wire        i_wr,
    input  wire        i_rd,
    input  wire [7:0]  i_wdata,
    output reg  [7:0]  o_rdata,
    input  wire        i_timer2_ovf,
    input  wire        i_timer3_ovf,
    input  wire        i_conversion_start_pin,
    input  wire        i_differential,
    input  wire        i_conv_irq_enable,
    input  wire [11:0] i_core_result,
    output wire        o_core_power_on,
    output wire        o_core_track,
    output wire        o_core_convert,
    output wire        o_sar_clk_en,
    output wire        o_conv_irq,
    output wire        o_window_irq
);
    // ****************************************
    // states
    // ****************************************
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_TRACK = 2'h1;
    localparam [1:0] ST_CONV  = 2'h2;

    reg  [7:0]  ctrl_r;
    reg  [7:0]  res_lo_r;
    reg  [7:0]  res_hi_r;
    reg  [7:0]  gt_lo_r;
    reg  [7:0]  gt_hi_r;
    reg  [7:0]  lt_lo_r;
    reg  [7:0]  lt_hi_r;
    reg  [1:0]  state_r;
    reg  [7:0]  div_r;
    reg  [3:0]  sar_cnt_r;
    reg         pin_s1_r;
    reg         pin_s2_r;
    reg         pin_s3_r;
    reg         busy_d_r;
    reg         eoc_d_r;
    reg  [15:0] word_r;

    wire       on_bit   = ctrl_r[`BIT_CONVERTER_ON];
    wire       tmode    = ctrl_r[`BIT_TRACK_MODE_SELECT];
    wire [1:0] src      = ctrl_r[`BIT_START_SRC_HI:`BIT_START_SRC_LO];
    wire       ljust    = ctrl_r[`BIT_LEFT_JUSTIFY];
    wire       busy     = (state_r != ST_IDLE);
    wire       ctl_wr   = i_wr & (i_addr == `OFS_CONVERTER_CONTROL);
    // sar_tick marks the last system clock of a sar period
    wire       sar_tick = (div_r == SAR_DIV[7:0] - 8'h01);
    wire       pin_src  = (src == `START_SRC_PIN);

    // ****************************************
    // start triggers
    // ****************************************
    // first sync stage read only by the second
    wire pin_rise = pin_s2_r & ~pin_s3_r;
    reg  trig;
    always @*
    begin
        case (src)
            `START_SRC_BUSY_WRITE: trig = ctl_wr & i_wdata[`BIT_CONVERSION_BUSY];
            `START_SRC_TIMER3:     trig = i_timer3_ovf;
            `START_SRC_PIN:        trig = pin_rise;
            `START_SRC_TIMER2:     trig = i_timer2_ovf;
            default:               trig = 1'b0;
        endcase
    end
    wire start = on_bit & trig & ~busy;

    // when pin mode tracks in idle, conversion skips the tracking phase
    wire pre_tracked = tmode & pin_src;
    wire eoc = (state_r == ST_CONV) & sar_tick &
               (sar_cnt_r == `CONVERT_SAR_CLOCKS - 4'h1);

    // ****************************************
    // sar clock divider
    // ****************************************
    // restarted by each start, so tracking and conversion are whole sar periods
    always @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            div_r <= 8'h00;
        else if (!on_bit || sar_tick || start)
            div_r <= 8'h00;
        else
            div_r <= div_r + 8'h01;
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    always @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_r   <= ST_IDLE;
            sar_cnt_r <= 4'h0;
        end
        else if (!on_bit)
        begin
            state_r   <= ST_IDLE;
            sar_cnt_r <= 4'h0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    sar_cnt_r <= 4'h0;
                    if (start)
                        state_r <= (tmode && !pre_tracked) ? ST_TRACK : ST_CONV;
                end
                ST_TRACK:
                begin
                    if (sar_tick)
                    begin
                        if (sar_cnt_r == `TRACK_SAR_CLOCKS - 4'h1)
                        begin
                            sar_cnt_r <= 4'h0;
                            state_r   <= ST_CONV;
                        end
                        else
                            sar_cnt_r <= sar_cnt_r + 4'h1;
                    end
                end
                ST_CONV:
                begin
                    if (eoc)
                        state_r <= ST_IDLE;
                    else if (sar_tick)
                        sar_cnt_r <= sar_cnt_r + 4'h1;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // result formatting
    // ****************************************
    // differential right-justified words sign-extend from bit 11
    function [15:0] justify;
        input [11:0] r;
        input        left;
        input        diff;
        begin
            if (left)
                justify = {r, 4'h0};
            else
                justify = {{4{diff & r[11]}}, r};
        end
    endfunction

    wire [15:0] new_word = justify(i_core_result, ljust, i_differential);
    wire        hit;

    window_compare u_window
    (
        .i_word   (word_r),
        .i_lower  ({gt_hi_r, gt_lo_r}),
        .i_upper  ({lt_hi_r, lt_lo_r}),
        .i_signed (i_differential),
        .o_hit    (hit)
    );

    // ****************************************
    // registers
    // ****************************************
    always @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ctrl_r   <= `RST_CONTROL;
            res_lo_r <= `RST_RESULT;
            res_hi_r <= `RST_RESULT;
            gt_lo_r  <= `RST_LOWER_LIMIT_LOW;
            gt_hi_r  <= `RST_LOWER_LIMIT_HIGH;
            lt_lo_r  <= `RST_UPPER_LIMIT;
            lt_hi_r  <= `RST_UPPER_LIMIT;
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
            pin_s3_r <= 1'b1;
            busy_d_r <= 1'b0;
            eoc_d_r  <= 1'b0;
            word_r   <= 16'h0000;
        end
        else
        begin
            pin_s1_r <= i_conversion_start_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            busy_d_r <= busy;
            eoc_d_r  <= eoc;
            if (ctl_wr)
            begin
                ctrl_r[7:6] <= i_wdata[7:6];
                ctrl_r[3:2] <= i_wdata[3:2];
                ctrl_r[0]   <= i_wdata[0];
            end
            // set wins over a software clear in the same cycle
            ctrl_r[`BIT_CONVERSION_DONE] <= eoc ? 1'b1 :
                ctl_wr ? i_wdata[`BIT_CONVERSION_DONE] : ctrl_r[`BIT_CONVERSION_DONE];
            ctrl_r[`BIT_WINDOW_HIT] <= (eoc_d_r & hit) ? 1'b1 :
                ctl_wr ? i_wdata[`BIT_WINDOW_HIT] : ctrl_r[`BIT_WINDOW_HIT];
            ctrl_r[`BIT_CONVERSION_BUSY] <= 1'b0;
            if (eoc)
            begin
                word_r   <= new_word;
                res_hi_r <= new_word[15:8];
                res_lo_r <= new_word[7:0];
            end
            else if (i_wr)
            begin
                if (i_addr == `OFS_RESULT_LOW)
                    res_lo_r <= i_wdata;
                if (i_addr == `OFS_RESULT_HIGH)
                    res_hi_r <= i_wdata;
            end
            if (i_wr)
            begin
                case (i_addr)
                    `OFS_LOWER_LIMIT_LOW:  gt_lo_r <= i_wdata;
                    `OFS_LOWER_LIMIT_HIGH: gt_hi_r <= i_wdata;
                    `OFS_UPPER_LIMIT_LOW:  lt_lo_r <= i_wdata;
                    `OFS_UPPER_LIMIT_HIGH: lt_hi_r <= i_wdata;
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_rdata <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                `OFS_RESULT_LOW:        o_rdata <= res_lo_r;
                `OFS_RESULT_HIGH:       o_rdata <= res_hi_r;
                `OFS_LOWER_LIMIT_LOW:   o_rdata <= gt_lo_r;
                `OFS_LOWER_LIMIT_HIGH:  o_rdata <= gt_hi_r;
                `OFS_UPPER_LIMIT_LOW:   o_rdata <= lt_lo_r;
                `OFS_UPPER_LIMIT_HIGH:  o_rdata <= lt_hi_r;
                `OFS_CONVERTER_CONTROL: o_rdata <= {ctrl_r[7:5], busy, ctrl_r[3:0]};
                default:                o_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // core controls
    // ****************************************
    assign o_core_power_on = on_bit;
    assign o_core_track    = on_bit & (tmode ?
                             ((state_r == ST_TRACK) |
                              (pin_src & ~busy & ~pin_s2_r))
                             : (state_r != ST_CONV));
    // gated so a disable drops the core at once, not one clock later
    assign o_core_convert  = on_bit & (state_r == ST_CONV);
    assign o_sar_clk_en    = on_bit & sar_tick;
    // limitation: an abort by disable also drops busy and raises the request
    assign o_conv_irq      = busy_d_r & ~busy & i_conv_irq_enable;
    assign o_window_irq    = ctrl_r[`BIT_WINDOW_HIT];
endmodule // conv_ctrl
`default_nettype wire

//--- hdl/conv_ctrl_map.vh
`ifndef CONV_CTRL_MAP_VH
`define CONV_CTRL_MAP_VH
// register offsets
`define OFS_RESULT_LOW          8'hbe
`define OFS_RESULT_HIGH         8'hbf
`define OFS_LOWER_LIMIT_LOW     8'hc4
`define OFS_LOWER_LIMIT_HIGH    8'hc5
`define OFS_UPPER_LIMIT_LOW     8'hc6
`define OFS_UPPER_LIMIT_HIGH    8'hc7
`define OFS_CONVERTER_CONTROL   8'he8
// converter_control fields
`define BIT_CONVERTER_ON        7
`define BIT_TRACK_MODE_SELECT   6
`define BIT_CONVERSION_DONE     5
`define BIT_CONVERSION_BUSY     4
`define BIT_START_SRC_HI        3
`define BIT_START_SRC_LO        2
`define BIT_WINDOW_HIT          1
`define BIT_LEFT_JUSTIFY        0
// start sources
`define START_SRC_BUSY_WRITE    2'h0
`define START_SRC_TIMER3        2'h1
`define START_SRC_PIN           2'h2
`define START_SRC_TIMER2        2'h3
// reset values
`define RST_CONTROL             8'h00
`define RST_RESULT              8'h00
`define RST_LOWER_LIMIT_LOW     8'hff
`define RST_LOWER_LIMIT_HIGH    8'hff
`define RST_UPPER_LIMIT         8'h00
// timing, in sar clock periods
`define TRACK_SAR_CLOCKS        4'h3
`define CONVERT_SAR_CLOCKS      4'hc
`endif

//--- hdl/window_compare.v
`timescale 1ns/1ps
`default_nettype none
module window_compare
(
    input  wire [15:0] i_word,
    input  wire [15:0] i_lower,
    input  wire [15:0] i_upper,
    input  wire        i_signed,
    output wire        o_hit
);
    // ****************************************
    // signed or unsigned ordering
    // ****************************************
    function less;
        input [15:0] a;
        input [15:0] b;
        input        sgn;
        begin
            if (sgn)
                less = ($signed(a) < $signed(b));
            else
                less = (a < b);
        end
    endfunction

    wire above_lower = less(i_lower, i_word, i_signed);
    wire below_upper = less(i_word, i_upper, i_signed);
    wire inside_mode = less(i_lower, i_upper, i_signed);

    // inside window or outside window per limit order
    assign o_hit = inside_mode ? (above_lower & below_upper)
                               : (above_lower | below_upper);
endmodule // window_compare
`default_nettype wire

//--- tb/conv_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// port checker, sees only the top ports
// ****************************************************************
module conv_ctrl_sva
(
    input wire logic       i_mclk,
    input wire logic       i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic       i_wr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_conv_irq_enable,
    input wire logic       o_core_power_on,
    input wire logic       o_core_track,
    input wire logic       o_core_convert,
    input wire logic       o_conv_irq,
    input wire logic       o_window_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    wire logic ctl_wr = i_wr && i_addr == 8'he8;
    chk_off_idle: assert property (!o_core_power_on |-> !o_core_convert && !o_core_track)
        else $error("converter active while off");
    chk_enable_follows: assert property (ctl_wr |=> o_core_power_on == $past(i_wdata[7]))
        else $error("enable output not following control write");
    chk_track_excl: assert property (o_core_convert |-> !o_core_track)
        else $error("tracking during conversion");
    // abort by disable is legal, so only a powered conversion must last
    chk_conv_min: assert property ($rose(o_core_convert) |-> (o_core_convert || !o_core_power_on)[*8])
        else $error("conversion too short");
    chk_conv_bound: assert property ($rose(o_core_convert) |-> ##[1:60] !o_core_convert)
        else $error("conversion never ends");
    chk_irq_cause: assert property ($fell(o_core_convert) && o_core_power_on && i_conv_irq_enable
        |-> ##[0:2] o_conv_irq)
        else $error("no interrupt after conversion");
    chk_irq_gated: assert property (o_conv_irq |-> i_conv_irq_enable && !o_core_convert)
        else $error("interrupt while disabled or busy");
    chk_irq_pulse: assert property (o_conv_irq |=> !o_conv_irq)
        else $error("interrupt longer than one cycle");
    chk_win_sticky: assert property (o_window_irq && !(ctl_wr && !i_wdata[1]) |=> o_window_irq)
        else $error("window flag dropped without software clear");
endmodule // conv_ctrl_sva
`default_nettype wire

//--- tb/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// analog core and free running timers
// ****************************************************************
module core_model
(
    input  wire logic        i_mclk,
    input  wire logic        i_resetn,
    input  wire logic        i_convert,
    input  wire logic [11:0] i_value,
    output logic      [11:0] o_result,
    output logic             o_timer2_ovf,
    output logic             o_timer3_ovf
);
    logic       conv_d_r;
    logic [7:0] t2_r;
    logic [7:0] t3_r;
    // stale data shows inverted, so a late sample is caught
    assign o_result = (i_convert || conv_d_r) ? i_value : ~i_value;
    assign o_timer2_ovf = (t2_r == 8'h00);
    assign o_timer3_ovf = (t3_r == 8'h00);
    always @(posedge i_mclk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            conv_d_r <= 1'b0;
            t2_r <= 8'h45;
            t3_r <= 8'h2c;
        end
        else
        begin
            conv_d_r <= i_convert;
            t2_r <= (t2_r == 8'h00) ? 8'h45 : t2_r - 8'h01;
            t3_r <= (t3_r == 8'h00) ? 8'h2c : t3_r - 8'h01;
        end
    end
endmodule // core_model
`default_nettype wire

//--- tb/conv_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// register level bench
// ****************************************************************
module conv_ctrl_tb_top;
    localparam int DIV = 2;
    logic        i_mclk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [7:0]  i_wdata = 8'h00;
    logic [7:0]  o_rdata;
    logic        t2, t3, pwr, trk, cnv, sclk, cirq, wirq, cnv_d, lj, hit;
    logic        pin = 1'b1;
    logic        diff = 1'b0;
    logic        irq_en = 1'b1;
    logic [11:0] value = 12'h000;
    logic [11:0] core_res;
    logic [15:0] lo, up;
    logic [7:0]  rd_v, hi;
    logic [46:0] tab [11];
    logic [15:0] rst_t [8];
    int          n_errors = 0, n_checks = 0, n_irq = 0, trk_n = 0, trk_last = 0, k;
    int          sclk_n = 0;
    conv_ctrl #(.SAR_DIV(DIV)) i_dut (.i_mclk, .i_resetn, .i_addr, .i_wr, .i_rd, .i_wdata,
        .o_rdata, .i_timer2_ovf(t2), .i_timer3_ovf(t3), .i_conversion_start_pin(pin),
        .i_differential(diff), .i_conv_irq_enable(irq_en), .i_core_result(core_res),
        .o_core_power_on(pwr), .o_core_track(trk), .o_core_convert(cnv), .o_sar_clk_en(sclk),
        .o_conv_irq(cirq), .o_window_irq(wirq));
    core_model i_core (.i_mclk, .i_resetn, .i_convert(cnv), .i_value(value),
        .o_result(core_res), .o_timer2_ovf(t2), .o_timer3_ovf(t3));
    initial
        forever #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        cnv_d <= cnv;
        trk_n <= trk ? trk_n + 1 : 0;
        if (cnv && !cnv_d) trk_last <= trk_n;
        if (cnv && sclk) sclk_n <= sclk_n + 1;
        if (cnv && !cnv_d) sclk_n <= 0;
        if (cirq === 1'b1) n_irq <= n_irq + 1;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) n_errors++;
        if (got !== exp) $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk) #1;
        {i_addr, i_wdata, i_wr} = {a, d, 1'b1};
        @(posedge i_mclk) #1;
        i_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_mclk) #1;
        {i_addr, i_rd} = {a, 1'b1};
        @(posedge i_mclk) #1;
        i_rd = 1'b0;
        rd_v = o_rdata;
    endtask
    // bounded poll, a lost conversion shows as a missing done flag
    task automatic wait_done();
        k = 0;
        do begin rd(8'he8); k++; end while (rd_v[5] !== 1'b1 && k < 100);
        chk("done_flag", 16'h1, 16'(rd_v[5]));
        chk("busy_flag", 16'h0, 16'(rd_v[4]));
    endtask
    function automatic logic [15:0] expw(input logic [11:0] r, input logic d, input logic l);
        return l ? {r, 4'h0} : {{4{d & r[11]}}, r};
    endfunction
    task automatic final_report();
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end
    initial
    begin
        rst_t = '{16'hbe00, 16'hbf00, 16'hc4ff, 16'hc5ff, 16'hc600, 16'hc700, 16'he800, 16'h1000};
        tab = '{{16'hffff, 16'h0000, 2'b00, 12'hfff, 1'b0}, {16'hffff, 16'h0000, 2'b01, 12'hfff, 1'b0},
            {16'h0100, 16'h0200, 2'b00, 12'h101, 1'b1}, {16'h0100, 16'h0200, 2'b00, 12'h200, 1'b0},
            {16'h0200, 16'h0100, 2'b00, 12'h0ff, 1'b1}, {16'h0200, 16'h0100, 2'b00, 12'h200, 1'b0},
            {16'hffff, 16'h0100, 2'b10, 12'h000, 1'b1}, {16'hffff, 16'h0100, 2'b10, 12'h800, 1'b0},
            {16'h0100, 16'hffff, 2'b11, 12'h7ff, 1'b1}, {16'h1000, 16'h2000, 2'b01, 12'h100, 1'b0},
            {16'h1000, 16'h2000, 2'b01, 12'h101, 1'b1}};
        repeat (10) @(posedge i_mclk);
        #1 i_resetn = 1'b1;
        foreach (rst_t[j]) begin rd(rst_t[j][15:8]); chk("reset", 16'(rst_t[j][7:0]), 16'(rd_v)); end
        foreach (tab[j])
        begin
            {lo, up, diff, lj, value, hit} = tab[j];
            wr(8'hc5, lo[15:8]); wr(8'hc4, lo[7:0]); wr(8'hc7, up[15:8]); wr(8'hc6, up[7:0]);
            wr(8'he8, {7'h40, lj});
            wr(8'he8, {7'h48, lj});
            wait_done();
            rd(8'hbf);
            hi = rd_v;
            rd(8'hbe);
            chk("result", expw(value, diff, lj), {hi, rd_v});
            rd(8'he8);
            chk("window", 16'(hit), 16'(rd_v[1]));
            chk("window_out", 16'(hit), 16'(wirq));
            chk("done_hold", 16'h1, 16'(rd_v[5]));
        end
        wr(8'he8, 8'h80);
        rd(8'he8);
        chk("flags_clear", 16'h80, 16'(rd_v));
        wr(8'he8, 8'hc0);
        wr(8'he8, 8'hd0);
        wait_done();
        chk("track_len", 16'(3 * DIV), 16'(trk_last));
        chk("sar_clocks", 16'd12, 16'(sclk_n));
        wr(8'he8, 8'h94);
        wait_done();
        wr(8'he8, 8'hdc);
        wait_done();
        chk("irq_count", 16'd14, 16'(n_irq));
        irq_en = 1'b0;
        wr(8'he8, 8'h98);
        rd(8'he8);
        chk("busy_refused", 16'h88, 16'(rd_v));
        pin = 1'b0;
        wr(8'he8, 8'hc8);
        chk("pin_track", 16'h1, 16'(trk));
        pin = 1'b1;
        wait_done();
        chk("irq_masked", 16'd14, 16'(n_irq));
        wr(8'he8, 8'h00);
        chk("power_off", 16'h0, 16'(pwr));
        final_report();
    end
endmodule // conv_ctrl_tb_top
bind conv_ctrl conv_ctrl_sva i_sva (.i_mclk, .i_resetn, .i_addr, .i_wr, .i_wdata,
    .i_conv_irq_enable, .o_core_power_on, .o_core_track, .o_core_convert, .o_conv_irq,
    .o_window_irq);
`default_nettype wire
